// File: src/pmu_misc_regs.svh
// Purpose: register indices, reset values and field positions of the power-management misc bank
// Assumes: indices are printed offsets; byte address is four times the index
// Notes: included by its bare name
`ifndef PMU_MISC_REGS_SVH
`define PMU_MISC_REGS_SVH
`define IDX_BEEPER 8'h51
`define IDX_SCRATCH_LO 8'h52
`define IDX_SCRATCH_HI 8'h53
`define IDX_LATCH_LO 8'h54
`define IDX_LATCH_HI 8'h55
`define IDX_PIN_DATA 8'h56
`define IDX_CTRL_SIX 8'h57
`define IDX_IRQ_STATUS 8'h60
`define IDX_IRQ_MASK 8'h61
`define RST_BYTE 8'h00
`define RST_LATCH_LO 4'h0
`define RST_LATCH_HI 4'hf
`define RST_IRQ 3'h0
`define BEEP_NOP 2'h0
`define BEEP_1K 2'h1
`define BEEP_OFF 2'h2
`define BEEP_2K 2'h3
`define CTRL_REFRESH 7
`define CTRL_INTGRP 6
`define CTRL_FDD_EXCL 5
`define CTRL_HDD_EXCL 4
`define IRQ_POWER_EVENT 0
`define IRQ_DISK 1
`define IRQ_PIN_CHANGE 2
`define CLK_HZ 50000000
`define TONE_1K_HZ 1000
`define TONE_2K_HZ 2000
`define HALF_1K ((`CLK_HZ / `TONE_1K_HZ) / 2)
`define HALF_2K ((`CLK_HZ / `TONE_2K_HZ) / 2)
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: src/pmu_misc_pkg.sv
// Purpose: types shared by the power-management misc bank
// Assumes: nothing beyond the header
// Notes: structs group the pin drive pair and the activity triple
package pmu_misc_pkg;
  typedef enum logic [1:0] {BEEP_IDLE_T = 2'b00, BEEP_LOW_T = 2'b01, BEEP_HIGH_T = 2'b10} tone_t;
  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe;
  } pin_drive_t;
  typedef struct packed {
    logic floppy;
    logic hard;
    logic intgrp;
  } activity_t;
endpackage

// File: src/tone_gen.sv
// Purpose: square-wave beeper tone from a divided one-cycle enable
// Assumes: single 50 MHz clock
// Notes: counter restarts whenever the tone changes
`timescale 1ns/100ps
`include "pmu_misc_regs.svh"
module tone_gen #(
  parameter int HALF_LOW = `HALF_1K,
  parameter int HALF_HIGH = `HALF_2K
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire pmu_misc_pkg::tone_t tone,
  output logic beep
);
  import pmu_misc_pkg::*;
  logic [15:0] cnt_reg, cnt_next;
  logic beep_reg, beep_next;
  tone_t tone_reg;
  logic [15:0] half;
  logic tick;

  always_comb
  begin
    half = (tone == BEEP_HIGH_T) ? 16'(HALF_HIGH - 1) : 16'(HALF_LOW - 1);
    tick = (cnt_reg == half);
    cnt_next = (tick || tone != tone_reg) ? 16'h0000 : cnt_reg + 16'h0001;
    if (tone == BEEP_IDLE_T)
      beep_next = 1'b0;
    else if (tick)
      beep_next = ~beep_reg;
    else
      beep_next = beep_reg;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_reg <= 16'h0000;
      beep_reg <= 1'b0;
      tone_reg <= BEEP_IDLE_T;
    end
    else
    begin
      cnt_reg <= cnt_next;
      beep_reg <= beep_next;
      tone_reg <= tone;
    end
  end
  assign beep = beep_reg;
endmodule

// File: src/masked_latch.sv
// Purpose: four output lines written through a per-line write-enable mask
// Assumes: mask and data arrive in one write
// Notes: reset level is a parameter so both latch banks share this module, each with its own level
`timescale 1ns/100ps
module masked_latch #(
  parameter logic [3:0] RESET_VAL = 4'h0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr,
  input wire logic [7:0] wdata,
  output logic [3:0] lines
);
  logic [3:0] lines_reg, lines_next;

  always_comb
  begin
    lines_next = lines_reg;
    if (wr)
      lines_next = (wdata[7:4] & wdata[3:0]) | (~wdata[7:4] & lines_reg);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      lines_reg <= RESET_VAL;
    else
      lines_reg <= lines_next;
  end
  assign lines = lines_reg;
endmodule

// File: src/pmu_misc_io_control_regs.sv
// Purpose: power-management misc register bank behind an AXI4-Lite slave
// Assumes: inputs synchronous to CLK; byte address = index * 4
// Notes: interrupt status bits clear on read; set wins over clear
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "pmu_misc_regs.svh"
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - beeper code 01 gives 1 kHz, 11 gives 2 kHz, 10 off, 00 unchanged
// - upper nibble of low latch register enables update of each low line
// - latch lower nibble is data: 0 drives low, 1 high; low lines reset low
// - high latch register works alike; its lines reset high
// - pin register reads pin levels; writes reach a pin only when output
// - control six low bits set pin direction: 0 input, 1 output
// - control six bit 7 enables refresh; resets to 0
// - control six bit 6 lets interrupt group activity raise power event six
// - control six bit 5 set excludes floppy accesses from disk activity
// - control six bit 4 set excludes hard-disk accesses from disk activity
module pmu_misc_io_control_regs (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [3:0] PROGRAMMABLE_PIN_IN,
  output pmu_misc_pkg::pin_drive_t PROGRAMMABLE_PIN_DRIVE,
  input wire pmu_misc_pkg::activity_t ACTIVITY_IN,
  output logic [3:0] POWER_LATCH_LOW_OUTPUTS,
  output logic [3:0] POWER_LATCH_HIGH_OUTPUTS,
  output logic BEEPER_OUT,
  output logic REFRESH_ENABLE,
  output logic POWER_EVENT_SIX,
  output logic DISK_ACTIVITY_EVENT,
  output logic IRQ
);
  import pmu_misc_pkg::*;

  function automatic logic [7:0] index_of(input logic [11:0] addr);
    index_of = addr[9:2];
  endfunction

  function automatic logic mapped(input logic [11:0] addr);
    logic [7:0] i;
    i = addr[9:2];
    mapped = (addr[11:10] == 2'h0) && ((i >= `IDX_BEEPER && i <= `IDX_CTRL_SIX) ||
      i == `IDX_IRQ_STATUS || i == `IDX_IRQ_MASK);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // write channel: address and data latched in either order
  logic [11:0] awaddr_reg, awaddr_next;
  logic aw_held_reg, aw_held_next;
  logic [7:0] wbyte_reg, wbyte_next;
  logic wstrb0_reg, wstrb0_next;
  logic w_held_reg, w_held_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic do_write;
  logic [7:0] widx;

  assign S_AXI_AWREADY = !aw_held_reg && !bvalid_reg;
  assign S_AXI_WREADY = !w_held_reg && !bvalid_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign widx = index_of(awaddr_reg);

  always_comb
  begin
    awaddr_next = awaddr_reg;
    aw_held_next = aw_held_reg;
    wbyte_next = wbyte_reg;
    wstrb0_next = wstrb0_reg;
    w_held_next = w_held_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      awaddr_next = S_AXI_AWADDR;
      aw_held_next = 1'b1;
    end
    if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      wbyte_next = S_AXI_WDATA[7:0];
      wstrb0_next = S_AXI_WSTRB[0];
      w_held_next = 1'b1;
    end
    if (do_write)
    begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = mapped(awaddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (bvalid_reg && S_AXI_BREADY)
      bvalid_next = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register contents
  logic wr_en;
  logic [7:0] beeper_reg, beeper_next;
  logic [7:0] scratch_lo_reg, scratch_lo_next;
  logic [7:0] scratch_hi_reg, scratch_hi_next;
  logic [3:0] pin_out_reg, pin_out_next;
  logic [7:0] ctrl_six_reg, ctrl_six_next;
  logic [2:0] irq_mask_reg, irq_mask_next;
  tone_t tone_reg, tone_next;

  // byte lane 0 carries every register; other lanes are ignored
  assign wr_en = do_write && wstrb0_reg;

  always_comb
  begin
    beeper_next = beeper_reg;
    scratch_lo_next = scratch_lo_reg;
    scratch_hi_next = scratch_hi_reg;
    pin_out_next = pin_out_reg;
    ctrl_six_next = ctrl_six_reg;
    irq_mask_next = irq_mask_reg;
    tone_next = tone_reg;
    if (wr_en)
    begin
      case (widx)
        `IDX_BEEPER:
        begin
          beeper_next = wbyte_reg;
          case (wbyte_reg[1:0])
            `BEEP_1K: tone_next = BEEP_LOW_T;
            `BEEP_2K: tone_next = BEEP_HIGH_T;
            `BEEP_OFF: tone_next = BEEP_IDLE_T;
            default: tone_next = tone_reg;
          endcase
        end
        `IDX_SCRATCH_LO: scratch_lo_next = wbyte_reg;
        `IDX_SCRATCH_HI: scratch_hi_next = wbyte_reg;
        `IDX_PIN_DATA: pin_out_next = wbyte_reg[3:0];
        `IDX_CTRL_SIX: ctrl_six_next = wbyte_reg;
        `IDX_IRQ_MASK: irq_mask_next = wbyte_reg[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      awaddr_reg <= 12'h000;
      aw_held_reg <= 1'b0;
      wbyte_reg <= `RST_BYTE;
      wstrb0_reg <= 1'b0;
      w_held_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      beeper_reg <= `RST_BYTE;
      scratch_lo_reg <= `RST_BYTE;
      scratch_hi_reg <= `RST_BYTE;
      pin_out_reg <= 4'h0;
      ctrl_six_reg <= `RST_BYTE;
      irq_mask_reg <= `RST_IRQ;
      tone_reg <= BEEP_IDLE_T;
    end
    else
    begin
      awaddr_reg <= awaddr_next;
      aw_held_reg <= aw_held_next;
      wbyte_reg <= wbyte_next;
      wstrb0_reg <= wstrb0_next;
      w_held_reg <= w_held_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      beeper_reg <= beeper_next;
      scratch_lo_reg <= scratch_lo_next;
      scratch_hi_reg <= scratch_hi_next;
      pin_out_reg <= pin_out_next;
      ctrl_six_reg <= ctrl_six_next;
      irq_mask_reg <= irq_mask_next;
      tone_reg <= tone_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // power latches: mask in the upper nibble, data in the lower
  logic [3:0] latch_lo, latch_hi;

  masked_latch #(.RESET_VAL(`RST_LATCH_LO)) u_latch_lo (
    .clk(CLK),
    .rst_n(RST_N),
    .wr(wr_en && widx == `IDX_LATCH_LO),
    .wdata(wbyte_reg),
    .lines(latch_lo)
  );

  masked_latch #(.RESET_VAL(`RST_LATCH_HI)) u_latch_hi (
    .clk(CLK),
    .rst_n(RST_N),
    .wr(wr_en && widx == `IDX_LATCH_HI),
    .wdata(wbyte_reg),
    .lines(latch_hi)
  );

  tone_gen u_tone (
    .clk(CLK),
    .rst_n(RST_N),
    .tone(tone_reg),
    .beep(BEEPER_OUT)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // derived outputs, registered
  logic refresh_reg, event_six_reg, disk_reg;
  logic refresh_next, event_six_next, disk_next;
  logic [3:0] pins_prev_reg;

  always_comb
  begin
    refresh_next = ctrl_six_reg[`CTRL_REFRESH];
    event_six_next = ctrl_six_reg[`CTRL_INTGRP] && ACTIVITY_IN.intgrp;
    disk_next = (ACTIVITY_IN.floppy && !ctrl_six_reg[`CTRL_FDD_EXCL]) ||
      (ACTIVITY_IN.hard && !ctrl_six_reg[`CTRL_HDD_EXCL]);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt status: sticky, cleared by reading it
  logic [2:0] irq_stat_reg, irq_stat_next;
  logic [2:0] irq_events;
  logic rd_status;

  always_comb
  begin
    irq_events = 3'h0;
    irq_events[`IRQ_POWER_EVENT] = event_six_next && !event_six_reg;
    irq_events[`IRQ_DISK] = disk_next && !disk_reg;
    irq_events[`IRQ_PIN_CHANGE] = |((PROGRAMMABLE_PIN_IN ^ pins_prev_reg) & ~ctrl_six_reg[3:0]);
    irq_stat_next = (rd_status ? 3'h0 : irq_stat_reg) | irq_events;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read channel: one cycle to data
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [7:0] rbyte;
  logic [7:0] ridx;

  assign S_AXI_ARREADY = !rvalid_reg;
  assign ridx = index_of(S_AXI_ARADDR);
  assign rd_status = S_AXI_ARVALID && S_AXI_ARREADY && mapped(S_AXI_ARADDR) &&
    ridx == `IDX_IRQ_STATUS;

  always_comb
  begin
    case (ridx)
      `IDX_BEEPER: rbyte = beeper_reg;
      `IDX_SCRATCH_LO: rbyte = scratch_lo_reg;
      `IDX_SCRATCH_HI: rbyte = scratch_hi_reg;
      `IDX_LATCH_LO: rbyte = {4'h0, latch_lo};
      `IDX_LATCH_HI: rbyte = {4'h0, latch_hi};
      `IDX_PIN_DATA: rbyte = {4'h0, PROGRAMMABLE_PIN_IN};
      `IDX_CTRL_SIX: rbyte = ctrl_six_reg;
      `IDX_IRQ_STATUS: rbyte = {5'h00, irq_stat_reg};
      `IDX_IRQ_MASK: rbyte = {5'h00, irq_mask_reg};
      default: rbyte = 8'h00;
    endcase
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      rvalid_next = 1'b1;
      rdata_next = mapped(S_AXI_ARADDR) ? {24'h000000, rbyte} : 32'h00000000;
      rresp_next = mapped(S_AXI_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rvalid_reg && S_AXI_RREADY)
      rvalid_next = 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      refresh_reg <= 1'b0;
      event_six_reg <= 1'b0;
      disk_reg <= 1'b0;
      pins_prev_reg <= 4'h0;
      irq_stat_reg <= `RST_IRQ;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `RESP_OKAY;
    end
    else
    begin
      refresh_reg <= refresh_next;
      event_six_reg <= event_six_next;
      disk_reg <= disk_next;
      pins_prev_reg <= PROGRAMMABLE_PIN_IN;
      irq_stat_reg <= irq_stat_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;
  // pins drive only when their direction bit says output
  assign PROGRAMMABLE_PIN_DRIVE = '{o: pin_out_reg, oe: ctrl_six_reg[3:0]};
  assign POWER_LATCH_LOW_OUTPUTS = latch_lo;
  assign POWER_LATCH_HIGH_OUTPUTS = latch_hi;
  assign REFRESH_ENABLE = refresh_reg;
  assign POWER_EVENT_SIX = event_six_reg;
  assign DISK_ACTIVITY_EVENT = disk_reg;
  assign IRQ = |(irq_stat_reg & irq_mask_reg);
endmodule

// File: tb/pmu_misc_monitor.sv
// Purpose: port-level assertions for the misc power-management register bank
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the top module at the foot of this file
`timescale 1ns/100ps
module pmu_misc_monitor
  import pmu_misc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire pmu_misc_pkg::activity_t ACTIVITY_IN,
  input wire pmu_misc_pkg::pin_drive_t PROGRAMMABLE_PIN_DRIVE,
  input wire logic [3:0] POWER_LATCH_LOW_OUTPUTS,
  input wire logic [3:0] POWER_LATCH_HIGH_OUTPUTS,
  input wire logic POWER_EVENT_SIX,
  input wire logic DISK_ACTIVITY_EVENT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////////////
  // latch lines and pin drive may only move while a write is being answered
  sequence wr_answer;
    S_AXI_BVALID || $past(S_AXI_BVALID);
  endsequence
  sequence rd_take;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_latch_lo_cause: assert property ($changed(POWER_LATCH_LOW_OUTPUTS) |-> wr_answer)
    else $error("low latch lines moved without a write");
  a_latch_hi_cause: assert property ($changed(POWER_LATCH_HIGH_OUTPUTS) |-> wr_answer)
    else $error("high latch lines moved without a write");
  a_drive_cause: assert property ($changed(PROGRAMMABLE_PIN_DRIVE) |-> wr_answer)
    else $error("pin drive moved without a write");
  a_event_six_gate: assert property (POWER_EVENT_SIX |-> $past(ACTIVITY_IN.intgrp))
    else $error("power event six without group activity");
  a_disk_cause: assert property (DISK_ACTIVITY_EVENT |->
    $past(ACTIVITY_IN.floppy) || $past(ACTIVITY_IN.hard))
    else $error("disk activity without a drive access");
  a_read_answer: assert property (rd_take |=> S_AXI_RVALID)
    else $error("read not answered next cycle");
  a_read_gap: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read data still valid after being taken");
  a_write_block: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response still valid after being taken");
endmodule

bind pmu_misc_io_control_regs pmu_misc_monitor pmu_misc_monitor_inst (.CLK(CLK),
  .RST_N(RST_N), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .ACTIVITY_IN(ACTIVITY_IN),
  .PROGRAMMABLE_PIN_DRIVE(PROGRAMMABLE_PIN_DRIVE),
  .POWER_LATCH_LOW_OUTPUTS(POWER_LATCH_LOW_OUTPUTS),
  .POWER_LATCH_HIGH_OUTPUTS(POWER_LATCH_HIGH_OUTPUTS),
  .POWER_EVENT_SIX(POWER_EVENT_SIX), .DISK_ACTIVITY_EVENT(DISK_ACTIVITY_EVENT));

// File: tb/tb_top.sv
// Purpose: self-checking bench for the misc power-management register bank
// Assumes: AXI4-Lite master in this module; the bus tasks wr and rd and the task pulse first wait for a rising edge
// Notes: tone checks dominate run time
`timescale 1ns/100ps
`include "pmu_misc_regs.svh"
module tb_top;
  import pmu_misc_pkg::*;
  localparam int LIMIT = 95000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf, pin_in = 4'h0, lat_lo, lat_hi;
  activity_t act = '0;
  logic awready, wready, bvalid, arready, rvalid, beep, refresh, ev6, disk, irq;
  logic [1:0] bresp, rresp;
  pin_drive_t drive;
  int n_mismatch = 0, n_compared = 0, cyc = 0;

  pmu_misc_io_control_regs pmu_misc_io_control_regs_inst (.CLK(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PROGRAMMABLE_PIN_IN(pin_in), .PROGRAMMABLE_PIN_DRIVE(drive), .ACTIVITY_IN(act),
    .POWER_LATCH_LOW_OUTPUTS(lat_lo), .POWER_LATCH_HIGH_OUTPUTS(lat_hi),
    .BEEPER_OUT(beep), .REFRESH_ENABLE(refresh), .POWER_EVENT_SIX(ev6),
    .DISK_ACTIVITY_EVENT(disk), .IRQ(irq));

  initial
  begin
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // upper data bits are random: the bank must ignore them on write
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'($urandom), d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk);
      if (awvalid && awready) aw_ok = 1'b1;
      if (wvalid && wready) w_ok = 1'b1;
      awvalid <= !aw_ok;
      wvalid <= !w_ok;
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic w(input logic [7:0] idx, input logic [7:0] d);
    logic [1:0] r;
    wr(idx, d, r);
    chk("bresp", r, `RESP_OKAY);
  endtask

  task automatic rc(input string what, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk(what, d, exp);
    chk("rresp", r, `RESP_OKAY);
  endtask

  // skips the partial first half, then counts one full half period
  task automatic half(input int exp);
    logic b;
    int n;
    for (int k = 0; k < 2; k++)
    begin
      b = beep;
      n = 0;
      do begin @(posedge clk); n++; end while (beep === b);
    end
    chk("beep half", n, exp);
  endtask

  // enabled lines take the data bit, the others keep their level
  function automatic logic [3:0] latch_exp(input logic [3:0] old, input logic [7:0] v);
    latch_exp = (old & ~v[7:4]) | (v[3:0] & v[7:4]);
  endfunction

  task automatic pulse;
    @(posedge clk);
    act <= activity_t'(3'h5);
    @(posedge clk);
    act <= '0;
    repeat (4) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] v, e;
    logic [3:0] m [2];
    logic [31:0] d;
    logic [1:0] r;
    void'($urandom(32'h5ba1));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("lo lines", lat_lo, `RST_LATCH_LO);
    chk("hi lines", lat_hi, `RST_LATCH_HI);
    rc("lo rst", `IDX_LATCH_LO, 32'h0);
    rc("hi rst", `IDX_LATCH_HI, 32'hf);
    rc("ctrl rst", `IDX_CTRL_SIX, 32'h0);
    rc("beep rst", `IDX_BEEPER, 32'h0);
    for (int k = 0; k < 8; k++)
    begin
      e = (k < 2) ? 8'hff : 8'($urandom);
      if (k < 2) rc("scr rst", 8'(`IDX_SCRATCH_LO + k), 32'h0);
      w(8'(`IDX_SCRATCH_LO + k % 2), e);
      rc("scratch", 8'(`IDX_SCRATCH_LO + k % 2), {24'h0, e});
    end
    w(`IDX_SCRATCH_LO, 8'h3c);
    wstrb <= 4'he;
    w(`IDX_SCRATCH_LO, 8'hc3);
    wstrb <= 4'hf;
    rc("strb", `IDX_SCRATCH_LO, 32'h3c);
    m[0] = `RST_LATCH_LO;
    m[1] = `RST_LATCH_HI;
    for (int k = 0; k < 14; k++)
    begin
      v = (k < 2) ? 8'h0a : 8'($urandom);
      m[k % 2] = latch_exp(m[k % 2], v);
      w(8'(`IDX_LATCH_LO + k % 2), v);
      chk("lo lines", lat_lo, m[0]);
      chk("hi lines", lat_hi, m[1]);
      rc("latch rd", 8'(`IDX_LATCH_LO + k % 2), {28'h0, m[k % 2]});
    end
    for (int k = 0; k < 16; k++)
    begin
      v = 8'($urandom);
      w(`IDX_CTRL_SIX, v);
      act <= activity_t'(3'($urandom));
      @(posedge clk);
      @(negedge clk);
      chk("refresh", refresh, v[7]);
      chk("event six", ev6, v[6] & act.intgrp);
      chk("disk", disk, (act.floppy & !v[5]) | (act.hard & !v[4]));
      chk("oe", drive.oe, v[3:0]);
      rc("ctrl rd", `IDX_CTRL_SIX, {24'h0, v});
    end
    for (int k = 0; k < 6; k++)
    begin
      v = 8'($urandom);
      e = 8'($urandom);
      w(`IDX_CTRL_SIX, {4'h0, v[3:0]});
      w(`IDX_PIN_DATA, e);
      chk("pin out", drive.o & v[3:0], e[3:0] & v[3:0]);
      pin_in <= 4'($urandom);
      @(negedge clk);
      rc("pin rd", `IDX_PIN_DATA, {28'h0, pin_in});
    end
    act <= '0;
    w(`IDX_CTRL_SIX, 8'h40);
    w(`IDX_IRQ_MASK, 8'h00);
    rd(`IDX_IRQ_STATUS, d, r);
    pulse();
    chk("irq masked", irq, 1'b0);
    rc("status", `IDX_IRQ_STATUS, 32'h3);
    w(`IDX_IRQ_MASK, 8'h07);
    pulse();
    chk("irq", irq, 1'b1);
    rc("status", `IDX_IRQ_STATUS, 32'h3);
    @(negedge clk);
    chk("irq clr", irq, 1'b0);
    @(posedge clk);
    pin_in <= ~pin_in;
    repeat (2) @(negedge clk);
    chk("irq pin", irq, 1'b1);
    rc("pin status", `IDX_IRQ_STATUS, 32'h4);
    w(`IDX_CTRL_SIX, 8'h0f);
    pin_in <= ~pin_in;
    rc("pin masked", `IDX_IRQ_STATUS, 32'h0);
    wr(8'h70, 8'h55, r);
    chk("bad wr", r, `RESP_SLVERR);
    rd(8'h70, d, r);
    chk("bad rd", d, 32'h0);
    chk("bad rresp", r, `RESP_SLVERR);
    w(`IDX_BEEPER, {6'h2a, `BEEP_2K});
    rc("beep rd", `IDX_BEEPER, 32'hab);
    half(`HALF_2K);
    w(`IDX_BEEPER, {6'h00, `BEEP_1K});
    w(`IDX_BEEPER, {6'h15, `BEEP_NOP});
    half(`HALF_1K);
    w(`IDX_BEEPER, {6'h00, `BEEP_OFF});
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("beep off", beep, 1'b0);
    wrap_up();
  end
endmodule
